// [src/isp_port.sv]
// I2C slave front end: framing, address pointer, write FIFO, read data port
`timescale 1ns/1ps
`include "isp_cfg.svh"
module isp_port #(
   parameter int FIFO_DEPTH = `ISP_FIFO_DEPTH,
   parameter int FILT_LEN   = `ISP_SPIKE_CYCLES
) (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        upper_die_i,
   output logic [7:0]       reg_addr_o,
   input  wire logic        reg_valid_i,
   input  wire logic [7:0]  reg_rdata_i,
   output logic [15:0]      wr_data_o,
   output logic             wr_valid_o,
   input  wire logic        wr_ready_i,
   output logic             busy_o
);
   import isp_pkg::*;

   logic [1:0]          scl_sync_reg;
   logic [1:0]          sda_sync_reg;
   logic                scl_f_reg;
   logic                sda_f_reg;
   logic                scl_prev_reg;
   logic                sda_prev_reg;
   logic [7:0]          scl_cnt_reg;
   logic [7:0]          sda_cnt_reg;
   logic [1:0]          die_sync_reg;
   logic                strap_reg;
   logic                wdata_byte_reg;
   isp_state_type       state_reg;
   isp_state_type       after_ack_reg;
   logic [3:0]          bit_cnt_reg;
   logic [7:0]          shift_reg;
   logic [7:0]          ptr_reg;
   logic                ack_reg;
   logic                reading_reg;
   logic                drive_reg;
   logic                ptr_adv_reg;
   logic                scl_rise;
   logic                scl_fall;
   logic                start_cond;
   logic                stop_cond;
   logic                held_addr;
   logic [7:0]          rx_byte;
   logic                fifo_in_ready;
   logic                fifo_push;
   logic [15:0]         fifo_in_data;

   // Two-stage synchronisers; only the second stage feeds the filters
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[0], scl_i};
         sda_sync_reg <= {sda_sync_reg[0], sda_i};
      end
   end

   // A line level is accepted only after it stays put for the spike width
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         scl_f_reg   <= 1'b1;
         sda_f_reg   <= 1'b1;
         scl_cnt_reg <= 8'h00;
         sda_cnt_reg <= 8'h00;
      end
      else
      begin
         if (scl_sync_reg[1] == scl_f_reg)
            scl_cnt_reg <= 8'h00;
         else if (scl_cnt_reg == 8'(FILT_LEN - 1))
         begin
            scl_f_reg   <= scl_sync_reg[1];
            scl_cnt_reg <= 8'h00;
         end
         else
            scl_cnt_reg <= scl_cnt_reg + 8'h01;
         if (sda_sync_reg[1] == sda_f_reg)
            sda_cnt_reg <= 8'h00;
         else if (sda_cnt_reg == 8'(FILT_LEN - 1))
         begin
            sda_f_reg   <= sda_sync_reg[1];
            sda_cnt_reg <= 8'h00;
         end
         else
            sda_cnt_reg <= sda_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end
      else
      begin
         scl_prev_reg <= scl_f_reg;
         sda_prev_reg <= sda_f_reg;
      end
   end

   // Die select strap is synchronised, then captured only while idle
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         die_sync_reg <= 2'h0;
         strap_reg    <= 1'b0;
      end
      else
      begin
         die_sync_reg <= {die_sync_reg[0], upper_die_i};
         if (state_reg == ST_IDLE)
            strap_reg <= die_sync_reg[1];
      end
   end

   assign scl_rise   = scl_f_reg && !scl_prev_reg;
   assign scl_fall   = !scl_f_reg && scl_prev_reg;
   assign start_cond = scl_f_reg && scl_prev_reg && sda_prev_reg && !sda_f_reg;
   assign stop_cond  = scl_f_reg && scl_prev_reg && !sda_prev_reg && sda_f_reg;
   assign rx_byte    = {shift_reg[6:0], sda_f_reg};
   assign held_addr  = (ptr_reg == `ISP_HELD_ANGLE_HI) || (ptr_reg == `ISP_HELD_RAW_HI)
                       || (ptr_reg == `ISP_HELD_FIELD_HI);

   // Byte framing; condition detection overrides any bit in progress
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_reg     <= ST_IDLE;
         after_ack_reg <= ST_IDLE;
         bit_cnt_reg   <= 4'h0;
         shift_reg     <= 8'h00;
         ack_reg       <= 1'b0;
         reading_reg   <= 1'b0;
      end
      else if (start_cond)
      begin
         state_reg   <= ST_ADDR;
         bit_cnt_reg <= 4'h0;
      end
      else if (stop_cond)
      begin
         state_reg <= ST_IDLE;
      end
      else
      begin
         case (state_reg)
            ST_ADDR, ST_WORD, ST_WDATA:
            begin
               if (scl_rise)
               begin
                  shift_reg   <= rx_byte;
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               if (scl_fall && bit_cnt_reg == 4'h8)
               begin
                  bit_cnt_reg <= 4'h0;
                  state_reg   <= ST_ACK;
                  if (state_reg == ST_ADDR)
                  begin
                     ack_reg <= shift_reg[7:1] == (strap_reg ? `ISP_ADDR_UPPER_DIE : `ISP_ADDR_LOWER_DIE);
                     reading_reg   <= shift_reg[0];
                     after_ack_reg <= shift_reg[0] ? ST_RDATA : ST_WORD;
                  end
                  else
                  begin
                     ack_reg       <= reg_valid_i;
                     after_ack_reg <= ST_WDATA;
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  if (!ack_reg && after_ack_reg != ST_WDATA)
                     state_reg <= ST_IDLE;
                  else
                     state_reg <= after_ack_reg;
                  if (after_ack_reg == ST_RDATA)
                     shift_reg <= reg_valid_i ? reg_rdata_i : 8'h00;
               end
            end
            ST_RDATA:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt_reg == 4'h7)
                  begin
                     bit_cnt_reg <= 4'h0;
                     state_reg   <= ST_MACK;
                  end
                  else
                  begin
                     shift_reg   <= {shift_reg[6:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            ST_MACK:
            begin
               if (scl_rise)
                  ack_reg <= !sda_f_reg;
               if (scl_fall)
               begin
                  if (ack_reg)
                  begin
                     state_reg <= ST_RDATA;
                     shift_reg <= reg_valid_i ? reg_rdata_i : 8'h00;
                  end
                  else
                     state_reg <= ST_IDLE;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Pointer: loaded by the word byte, moved after every data byte except a read of a valid held address
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ptr_reg     <= `ISP_PTR_RESET;
         ptr_adv_reg <= 1'b0;
      end
      else
      begin
         ptr_adv_reg <= 1'b0;
         // Loaded at the eighth rise so the valid flag of the new address is ready for its acknowledge
         if (scl_rise && bit_cnt_reg == 4'h7 && state_reg == ST_WORD && !start_cond && !stop_cond)
            ptr_reg <= rx_byte;
         else if (ptr_adv_reg)
            ptr_reg <= ptr_reg + 8'h01;
         // Data write byte finished: advance after its acknowledge
         if (scl_fall && state_reg == ST_ACK && after_ack_reg == ST_WDATA && reading_reg == 1'b0
             && wdata_byte_reg)
            ptr_adv_reg <= 1'b1;
         if (scl_rise && state_reg == ST_MACK && !(held_addr && reg_valid_i))
            ptr_adv_reg <= 1'b1;
      end
   end

   // True only for data bytes, not for the word byte that loaded the pointer
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
         wdata_byte_reg <= 1'b0;
      else if (scl_fall && bit_cnt_reg == 4'h8)
         wdata_byte_reg <= state_reg == ST_WDATA;
   end

   // SDA drive: open drain, low only for ACK or a zero data bit
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
         drive_reg <= 1'b0;
      else if (start_cond || stop_cond)
         drive_reg <= 1'b0;
      else if (scl_fall)
      begin
         if (bit_cnt_reg == 4'h8 && state_reg != ST_RDATA && state_reg != ST_MACK && state_reg != ST_ACK)
            drive_reg <= (state_reg == ST_ADDR)
                         ? (shift_reg[7:1] == (strap_reg ? `ISP_ADDR_UPPER_DIE : `ISP_ADDR_LOWER_DIE))
                         : reg_valid_i;
         else if (state_reg == ST_ACK && after_ack_reg == ST_RDATA && ack_reg)
            drive_reg <= !(reg_valid_i ? reg_rdata_i[7] : 1'b0);
         else if (state_reg == ST_RDATA && bit_cnt_reg != 4'h7)
            drive_reg <= !shift_reg[6];
         else if (state_reg == ST_MACK && ack_reg)
            drive_reg <= !(reg_valid_i ? reg_rdata_i[7] : 1'b0);
         else
            drive_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sda_o      <= 1'b1;
         sda_oe_o   <= 1'b0;
         busy_o     <= 1'b0;
         reg_addr_o <= `ISP_PTR_RESET;
      end
      else
      begin
         sda_o      <= 1'b0;
         sda_oe_o   <= drive_reg;
         busy_o     <= state_reg != ST_IDLE;
         reg_addr_o <= ptr_reg;
      end
   end

   // Accepted writes carry their address; invalid ones are dropped here
   assign fifo_push    = scl_fall && bit_cnt_reg == 4'h8 && state_reg == ST_WDATA
                         && reg_valid_i && !start_cond && !stop_cond;
   assign fifo_in_data = {ptr_reg, shift_reg};

   // Back-pressure limitation: a full FIFO loses the byte, so drain faster than SCL
   isp_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .reset_i     (reset_i),
      .in_data_i   (fifo_in_data),
      .in_valid_i  (fifo_push && fifo_in_ready),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (wr_data_o),
      .out_valid_o (wr_valid_o),
      .out_ready_i (wr_ready_i)
   );

   // Acknowledge stays asserted across the high phase of the ninth clock
   ack_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == ST_ACK && scl_f_reg && ack_reg && !start_cond && !stop_cond) |-> sda_oe_o || $past(scl_rise))
      else $error("ack not held during ninth clock");
   start_det_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      start_cond |=> state_reg == ST_ADDR)
      else $error("start not recognised");
   stop_det_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (stop_cond && !start_cond) |=> state_reg == ST_IDLE)
      else $error("stop not recognised");
   ptr_load_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (scl_rise && bit_cnt_reg == 4'h7 && state_reg == ST_WORD && !start_cond && !stop_cond)
      |=> ptr_reg == $past(rx_byte))
      else $error("word byte not loaded into pointer");
   ptr_wrap_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (ptr_adv_reg && ptr_reg == 8'hFF) |=> ptr_reg == 8'h00)
      else $error("pointer did not wrap");
   held_ptr_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (scl_rise && state_reg == ST_MACK && held_addr && reg_valid_i) |=> !ptr_adv_reg)
      else $error("pointer moved on held read");
   invalid_drop_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (fifo_push) |-> reg_valid_i)
      else $error("invalid byte stored");
   release_nack_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == ST_MACK && scl_fall && !ack_reg) |=> ##1 !drive_reg)
      else $error("sda kept after master nack");
endmodule // isp_port

// [src/isp_cfg.svh]
// Constants for the I2C slave register port
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH
`define ISP_CLK_PERIOD_PS   5000
`define ISP_SPIKE_NS        50
`define ISP_SPIKE_CYCLES    (((`ISP_SPIKE_NS * 1000) + `ISP_CLK_PERIOD_PS - 1) / `ISP_CLK_PERIOD_PS)
`define ISP_ADDR_LOWER_DIE  7'h40
`define ISP_ADDR_UPPER_DIE  7'h41
`define ISP_HELD_ANGLE_HI   8'h0E
`define ISP_HELD_RAW_HI     8'h0C
`define ISP_HELD_FIELD_HI   8'h1B
`define ISP_PTR_RESET       8'h00
`define ISP_FIFO_DEPTH      8
`endif

// [src/isp_pkg.sv]
// Types for the I2C slave register port
package isp_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_WORD,
      ST_WDATA,
      ST_RDATA,
      ST_ACK,
      ST_MACK
   } isp_state_type;
endpackage

// [src/isp_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides, registered read data
`timescale 1ns/1ps
module isp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // The output stage counts as one entry so full and empty stay honest
   assign push = in_valid_i && in_ready_o;
   assign pop  = (count_reg != '0) && (!out_valid_o || out_ready_i);

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         in_ready_o <= 1'b0;
      end
      else
      begin
         in_ready_o <= (count_reg + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH - 1);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wr_ptr_reg  <= '0;
         rd_ptr_reg  <= '0;
         count_reg   <= '0;
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            out_data_o <= mem_reg[rd_ptr_reg];
            out_valid_o <= 1'b1;
         end
         else if (out_ready_i)
         begin
            out_valid_o <= 1'b0;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // isp_fifo

// [tb/isp_host.sv]
// Behavioural I2C bus master with a 64 ns link clock that stands high between frames
`timescale 1ns/1ps
module isp_host (
   output logic      scl_o,
   output logic      sda_low_o,
   input  wire logic sda_i
);
   logic unstable = 1'b0;

   initial
   begin
      scl_o = 1'b1;  // Bus idle with both lines high
      sda_low_o = 1'b0;
   end

   // Low phase 40 ns, high 24 ns; g adds spikes shorter than the filter
   task automatic bit_io(input logic b, input logic g, output logic r);
      #20 sda_low_o = ~b;  // Data moves only while the clock is low
      #12 scl_o = g;
      #4 scl_o = 1'b0;
      #4 scl_o = 1'b1;
      #6 r = sda_i;
      if (g)
      begin
         sda_low_o = ~sda_low_o;
      end
      #4 sda_low_o = ~b;
      // A slave that moves the line in the high phase shows up here
      #14 if (sda_i !== r) unstable = 1'b1;
      scl_o = 1'b0;
   endtask

   task automatic start();
      #20 sda_low_o = 1'b0;
      #20 scl_o = 1'b1;
      #20 sda_low_o = 1'b1;
      #20 scl_o = 1'b0;
   endtask

   task automatic stop();
      #20 sda_low_o = 1'b1;
      #20 scl_o = 1'b1;
      #20 sda_low_o = 1'b0;
      #40;
   endtask

   task automatic wr_byte(input logic [7:0] d, input logic g, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], g && i == 3, r);
      bit_io(1'b1, 1'b0, ack);  // Ninth clock
   endtask

   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, 1'b0, r);
         d[i] = r;
      end
      bit_io(last, 1'b0, r);  // Withheld ack ends the read
   endtask
endmodule // isp_host

// [tb/isp_port_bench.sv]
// Self-checking bench of the I2C slave register port
`timescale 1ns/1ps
`include "isp_cfg.svh"
module isp_port_bench;
   logic        ref_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        upper_die_i = 1'b0;
   logic        wr_ready_i = 1'b0;
   logic        stall = 1'b1;
   logic        sda_o, sda_oe_o, wr_valid_o, busy_o;
   logic [7:0]  reg_addr_o, ptr;
   logic [15:0] wr_data_o;
   logic [6:0]  dev;
   logic [7:0]  mem [256];
   logic        vld [256];
   logic [15:0] got [$];
   logic [15:0] exp_q [$];
   int          failures = 0, check_count = 0, seed = 10, cyc = 0;
   wire         scl, sda_low;
   wire         sda = (sda_oe_o ? sda_o : 1'b1) & ~sda_low;
   // Register file answers at once for the current pointer
   wire         reg_valid = vld[reg_addr_o];
   wire  [7:0]  reg_rdata = mem[reg_addr_o];

   isp_port #(.FIFO_DEPTH(8), .FILT_LEN(2)) uut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .upper_die_i(upper_die_i), .reg_addr_o(reg_addr_o),
      .reg_valid_i(reg_valid), .reg_rdata_i(reg_rdata), .wr_data_o(wr_data_o),
      .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .busy_o(busy_o));
   isp_host host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));

   initial forever #2.5 ref_clk_i = ~ref_clk_i;

   always @(negedge ref_clk_i) wr_ready_i <= stall ? 1'b0 : 1'($random(seed));
   always @(posedge ref_clk_i)
   begin
      if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) got.push_back(wr_data_o);
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Whole bench needs about 8600 cycles
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         failures++;
         complete_run();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expd);
      check_count++;
      if (seen !== expd)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, expd, seen);
      end
   endtask

   // Reads stay on the high byte of an output register
   function automatic logic [7:0] step(input logic [7:0] p);
      if (vld[p] && (p == `ISP_HELD_RAW_HI || p == `ISP_HELD_ANGLE_HI || p == `ISP_HELD_FIELD_HI))
         return p;
      return p + 8'h01;
   endfunction

   task automatic wr_seq(input logic [7:0] word, input int n);
      logic       a;
      logic [7:0] d;
      host.start();
      host.wr_byte({dev, 1'b0}, 1'b0, a);
      check("address ack", 16'(a), 16'h0000);
      check("busy", 16'(busy_o), 16'h0001);
      host.wr_byte(word, 1'b0, a);
      ptr = word;
      check("word ack", 16'(a), 16'(!vld[ptr]));
      for (int i = 0; i < n; i++)
      begin
         d = 8'($random(seed));
         host.wr_byte(d, i == 1, a);
         // A full buffer drops the byte; its answer is left open
         if (exp_q.size() < 8)
         begin
            check("data ack", 16'(a), 16'(!vld[ptr]));
            if (vld[ptr]) exp_q.push_back({ptr, d});
         end
         ptr = ptr + 8'h01;
      end
      host.stop();
   endtask

   task automatic rd_seq(input int n, input logic setptr, input logic [7:0] word);
      logic       a;
      logic [7:0] d;
      if (setptr)
      begin
         host.start();
         host.wr_byte({dev, 1'b0}, 1'b0, a);
         host.wr_byte(word, 1'b0, a);
         ptr = word;
      end
      host.start();
      host.wr_byte({dev, 1'b1}, 1'b0, a);
      check("read address ack", 16'(a), 16'h0000);
      for (int i = 0; i < n; i++)
      begin
         host.rd_byte(i == n - 1, d);
         check("read data", 16'(d), vld[ptr] ? 16'(mem[ptr]) : 16'h0000);
         ptr = step(ptr);
      end
      #35 check("sda released", 16'(sda), 16'h0001);
      host.stop();
   endtask

   initial
   begin
      logic a;
      for (int i = 0; i < 256; i++)
      begin
         mem[i] = 8'($random(seed));
         vld[i] = 1'($random(seed));
      end
      for (int i = 8'h0C; i < 8'h10; i++) vld[i] = 1'b1;
      for (int i = 8'h20; i < 8'h2A; i++) vld[i] = 1'b1;
      vld[8'h1B] = 1'b1;
      repeat (8) @(posedge ref_clk_i);
      @(negedge ref_clk_i) reset_i = 1'b0;
      repeat (10) @(negedge ref_clk_i);
      for (int die = 0; die < 2; die++)
      begin
         @(negedge ref_clk_i) upper_die_i = 1'(die);
         dev = die ? `ISP_ADDR_UPPER_DIE : `ISP_ADDR_LOWER_DIE;
         stall = 1'b1;
         // Stalled buffer: wrap at the top, then overfill with ten valid bytes
         if (die == 0) wr_seq(8'hFC, 8);
         else wr_seq(8'h20, 10);
         @(negedge ref_clk_i) stall = 1'b0;
         repeat (300) @(negedge ref_clk_i);
         check("busy", 16'(busy_o), 16'h0000);
         check("words stored", 16'(got.size()), 16'(exp_q.size()));
         for (int i = 0; i < got.size() && i < exp_q.size(); i++)
            check("stored word", got[i], exp_q[i]);
         got.delete();
         exp_q.delete();
         host.start();
         host.wr_byte({dev ^ 7'h01, 1'b0}, 1'b0, a);
         check("foreign address ack", 16'(a), 16'h0001);
         host.stop();
      end
      rd_seq(2, 1'b0, 8'h00);
      rd_seq(4, 1'b1, 8'h0C);
      rd_seq(3, 1'b1, 8'h0D);
      rd_seq(2, 1'b0, 8'h00);
      rd_seq(3, 1'b1, 8'h1A);
      rd_seq(4, 1'b1, 8'hFE);
      rd_seq(6, 1'b1, 8'($random(seed)));
      check("sda stable in high phase", 16'(host.unstable), 16'h0000);
      complete_run();
   end
endmodule // isp_port_bench
